// *** verilog/dmc_channel.sv ***
// one dma channel: control, event handling, chaining and the shared crc registers
// Behaviour
// - crc data write seeds generator; read returns current accumulated crc
// - shift-register mode reads zero above the programmed polynomial length
// - checksum mode uses low 16 bits; upper 16 bits read zero
// - checksum mode reads the value back in ones'-complement form
// - set xor tap bit feeds back into that stage; clear bit shifts through
// - xor taps have no effect in checksum mode
// - busy reads 1 while channel enabled or active, else 0
// - chain direction 1 follows lower-priority neighbour, 0 the higher one
// - chain allow gates chaining; direction matters only when allowed
// - clearing enable finishes current transaction first; software polls busy
// - events while off recorded only when events-while-off bit is set
// - auto re-arm keeps channel on after block; else enable clears
// - event seen reads 1 after a start or abort event
// - two-bit priority ranks channel, 11 highest, 00 lowest
// - selected abort irq number aborts transfer and sets abort flag
// - selected start irq number starts a transfer on this channel
// - writing 1 to force begins a transfer; bit reads 0
// - writing 1 to abort ends the transfer; bit reads 0
// - pattern abort enable: match aborts and clears enable; else ignored
// - start irq enable gates the start irq number
// - abort irq enable gates the abort irq number
// - crc type 1 selects ip checksum, 0 shift-register crc
// - polynomial length field holds length minus one, sets crc width
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ns
module dmc_channel
  import dmc_pkg::*;
(
  input  wire logic        clk,             // 10 mhz system clock
  input  wire logic        reset_n,         // asynchronous reset, active low
  input  wire logic        psel,            // apb select
  input  wire logic        penable,         // apb access phase
  input  wire logic        pwrite,          // apb direction
  input  wire logic [7:0]  paddr,           // apb byte address
  input  wire logic [31:0] pwdata,          // apb write data
  output logic      [31:0] prdata,          // apb read data
  output logic             pready,          // apb ready
  output logic             pslverr,         // apb error on unmapped address
  input  wire logic        irqValid,        // interrupt number below is occurring
  input  wire logic [7:0]  irqNum,          // interrupt request number
  input  wire logic        cellDone,        // mover finished the current cell
  input  wire logic        blockDone,       // mover finished the block
  input  wire logic        patternMatch,    // mover saw the data pattern
  input  wire logic        higherChainDone, // higher-priority neighbour finished
  input  wire logic        lowerChainDone,  // lower-priority neighbour finished
  input  wire logic        crcValid,        // data word for the crc generator
  input  wire logic [31:0] crcData,         // word routed through the crc
  output logic             xferReq,         // cell transfer requested
  output logic             xferAbort,       // one-cycle abort to the mover
  output logic             chanOn,          // channel enable
  output logic             chanBusy,        // channel busy
  output logic      [1:0]  chanPriority,    // arbitration priority
  output logic             abortFlag        // sticky abort flag
);

  dmc_state_s q;
  dmc_state_s d;

  function automatic logic [31:0] lenMask(input logic [4:0] poly_length_minus_one);
    logic [32:0] m;
    m = (33'h000000002 << poly_length_minus_one) - 33'h000000001;
    return m[31:0];
  endfunction : lenMask

  // msb-first shift over the programmed width, one data bit per step
  function automatic logic [31:0] lfsrWord(input logic [31:0] acc, input logic [31:0] taps,
                                           input logic [4:0] poly_length_minus_one, input logic [31:0] din);
    logic [31:0] a;
    logic        fb;
    a = acc;
    for (int i = 31; i >= 0; i--) begin
      fb = a[poly_length_minus_one] ^ din[i];
      a  = a << 1;
      for (int j = 0; j < 32; j++) begin
        if (taps[j]) begin
          a[j] = a[j] ^ fb;
        end
      end
    end
    return a & lenMask(poly_length_minus_one);
  endfunction : lfsrWord

  // end-around carry sum of both halves
  function automatic logic [15:0] ipSum(input logic [15:0] acc, input logic [31:0] din);
    logic [17:0] s;
    logic [16:0] t;
    s = {2'b00, acc} + {2'b00, din[31:16]} + {2'b00, din[15:0]};
    t = {1'b0, s[15:0]} + {15'h0000, s[17:16]};
    t = {1'b0, t[15:0]} + {16'h0000, t[16]};
    return t[15:0];
  endfunction : ipSum

  logic        wrEn;
  logic        startHit;
  logic        abortHit;
  logic        accept;
  logic        chainHit;
  logic        hit;
  logic [31:0] rdMux;
  logic [31:0] crcRead;

  always_comb begin
    d           = q;
    d.xferAbort = 1'b0;
    wrEn        = psel & penable & pwrite & q.pready;
    // read view of the accumulator depends on mode
    if (q.crcType) begin
      crcRead = {16'h0000, ~q.crcAcc[IP_SUM_W-1:0]};
    end else begin
      crcRead = q.crcAcc & lenMask(q.polyLen);
    end
    hit   = 1'b1;
    rdMux = 32'h00000000;
    unique case (paddr)
      CRC_CONTROL_OFS: begin
        rdMux[CRC_TYPE_BIT] = q.crcType;
        rdMux[POLY_LENGTH_MINUS_ONE_LSB +: POLY_LENGTH_MINUS_ONE_W] = q.polyLen;
      end
      CRC_SEED_OFS: rdMux = crcRead;
      CRC_TAPS_OFS: rdMux = q.crcTaps;
      CHAN_CONTROL_OFS: begin
        rdMux[BUSY_BIT]      = q.chanOn | (q.chan != CH_IDLE);
        rdMux[CHAIN_DIR_BIT] = q.chainDir;
        rdMux[CHAN_ON_BIT]   = q.chanOn;
        rdMux[EVT_OFF_BIT]   = q.eventsWhileOff;
        rdMux[CHAIN_OK_BIT]  = q.chainAllow;
        rdMux[REARM_BIT]     = q.autoRearm;
        rdMux[EVT_SEEN_BIT]  = q.eventSeen;
        rdMux[PRIO_LSB +: 2] = q.prio;
      end
      CHAN_EVENT_OFS: begin
        // force and abort strobes are never stored, so they read 0
        rdMux[ABORT_IRQ_LSB +: 8] = q.abortIrq;
        rdMux[START_IRQ_LSB +: 8] = q.startIrq;
        rdMux[PAT_EN_BIT]         = q.patAbortEn;
        rdMux[START_EN_BIT]       = q.startIrqEn;
        rdMux[ABORT_EN_BIT]       = q.abortIrqEn;
      end
      CHAN_STATUS_OFS: rdMux[ABORT_FLAG_BIT] = q.abortFlag;
      default: hit = 1'b0;
    endcase
    // one wait state so read data comes from a flop
    if (psel & penable & ~q.pready) begin
      d.pready  = 1'b1;
      d.pslverr = ~hit;
      d.prdata  = hit ? rdMux : 32'h00000000;
    end else begin
      d.pready  = 1'b0;
      d.pslverr = 1'b0;
    end

    startHit = 1'b0;
    abortHit = 1'b0;
    if (wrEn & hit) begin
      unique case (paddr)
        CRC_CONTROL_OFS: begin
          d.crcType = pwdata[CRC_TYPE_BIT];
          d.polyLen = pwdata[POLY_LENGTH_MINUS_ONE_LSB +: POLY_LENGTH_MINUS_ONE_W];
        end
        CRC_SEED_OFS: d.crcAcc = pwdata;
        CRC_TAPS_OFS: d.crcTaps = pwdata;
        CHAN_CONTROL_OFS: begin
          d.chainDir       = pwdata[CHAIN_DIR_BIT];
          d.chanOn         = pwdata[CHAN_ON_BIT];
          d.eventsWhileOff = pwdata[EVT_OFF_BIT];
          d.chainAllow     = pwdata[CHAIN_OK_BIT];
          d.autoRearm      = pwdata[REARM_BIT];
          d.prio           = pwdata[PRIO_LSB +: 2];
          d.eventSeen      = 1'b0;
        end
        CHAN_EVENT_OFS: begin
          d.abortIrq   = pwdata[ABORT_IRQ_LSB +: 8];
          d.startIrq   = pwdata[START_IRQ_LSB +: 8];
          d.patAbortEn = pwdata[PAT_EN_BIT];
          d.startIrqEn = pwdata[START_EN_BIT];
          d.abortIrqEn = pwdata[ABORT_EN_BIT];
          startHit     = pwdata[FORCE_BIT];
          abortHit     = pwdata[ABORT_BIT];
        end
        CHAN_STATUS_OFS: begin
          if (pwdata[ABORT_FLAG_BIT]) begin
            d.abortFlag = 1'b0;
          end
        end
        default: d.abortFlag = q.abortFlag;
      endcase
    end

    startHit = startHit | (irqValid & q.startIrqEn & (irqNum == q.startIrq));
    abortHit = abortHit | (irqValid & q.abortIrqEn & (irqNum == q.abortIrq));
    accept   = q.chanOn | q.eventsWhileOff;
    chainHit = q.chainAllow & (q.chainDir ? lowerChainDone : higherChainDone);
    if (chainHit) begin
      d.chanOn = 1'b1;
    end

    // transfer sequencing; an abort outranks a start in the same cycle
    if (abortHit & accept) begin
      d.eventSeen = 1'b1;
      d.abortFlag = 1'b1;
      d.pendStart = 1'b0;
      d.xferReq   = 1'b0;
      d.chan      = CH_IDLE;
      d.xferAbort = q.chan != CH_IDLE;
    end else if (patternMatch & q.patAbortEn & (q.chan != CH_IDLE)) begin
      d.chanOn    = 1'b0;
      d.pendStart = 1'b0;
      d.xferReq   = 1'b0;
      d.chan      = CH_IDLE;
      d.xferAbort = 1'b1;
    end else begin
      if (startHit & accept) begin
        d.eventSeen = 1'b1;
        d.pendStart = 1'b1;
      end
      unique case (q.chan)
        CH_IDLE: begin
          if (q.chanOn & (q.pendStart | (startHit & accept))) begin
            d.chan      = CH_ACTIVE;
            d.xferReq   = 1'b1;
            d.pendStart = 1'b0;
          end
        end
        CH_ACTIVE, CH_SUSPEND: begin
          // a cleared enable lets the running cell finish before going idle
          if (~d.chanOn) begin
            d.chan = CH_SUSPEND;
          end
          if (cellDone) begin
            d.chan    = CH_IDLE;
            d.xferReq = 1'b0;
            if (blockDone & ~q.autoRearm) begin
              d.chanOn = 1'b0;
            end
          end
        end
        default: d.chan = CH_IDLE;
      endcase
    end

    // hardware update wins over a seed write in the same cycle
    if (crcValid) begin
      if (q.crcType) begin
        d.crcAcc = {16'h0000, ipSum(q.crcAcc[IP_SUM_W-1:0], crcData)};
      end else begin
        d.crcAcc = lfsrWord(q.crcAcc, q.crcTaps, q.polyLen, crcData);
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q          <= '0;
      q.abortIrq <= IRQ_NUM_RST;
      q.startIrq <= IRQ_NUM_RST;
      q.chan     <= CH_IDLE;
      chanBusy   <= 1'b0;
    end else begin
      q        <= d;
      chanBusy <= d.chanOn | (d.chan != CH_IDLE);
    end
  end

  assign prdata       = q.prdata;
  assign pready       = q.pready;
  assign pslverr      = q.pslverr;
  assign xferReq      = q.xferReq;
  assign xferAbort    = q.xferAbort;
  assign chanOn       = q.chanOn;
  assign chanPriority = q.prio;
  assign abortFlag    = q.abortFlag;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_busy_tracks_state: assert property (
    chanBusy == (q.chanOn | (q.chan != CH_IDLE)))
    else $error("busy does not follow enable and activity");

  a_suspend_holds_req: assert property (
    (q.chan == CH_ACTIVE && !d.chanOn && !cellDone && !abortHit && !patternMatch)
      |=> xferReq && q.chan == CH_SUSPEND)
    else $error("transfer dropped before its cell finished");

  a_block_clears_on: assert property (
    (q.chan != CH_IDLE && cellDone && blockDone && !q.autoRearm && !abortHit && !chainHit)
      |=> !chanOn)
    else $error("enable kept after block without re-arm");

  a_rearm_keeps_on: assert property (
    (q.chan != CH_IDLE && cellDone && blockDone && q.autoRearm && chanOn && !wrEn
      && !abortHit && !patternMatch) |=> chanOn)
    else $error("re-armed channel lost its enable");

  a_abort_sets_flag: assert property (
    (irqValid && q.abortIrqEn && irqNum == q.abortIrq && chanOn)
      |=> abortFlag && !xferReq && q.eventSeen)
    else $error("abort irq did not abort and flag");

  a_off_events_drop: assert property (
    (!q.chanOn && !q.eventsWhileOff && !chainHit && q.chan == CH_IDLE && !q.pendStart
      && !wrEn) |=> !q.pendStart)
    else $error("event recorded while channel off");

  a_start_launches: assert property (
    (q.chan == CH_IDLE && chanOn && irqValid && q.startIrqEn && irqNum == q.startIrq
      && !abortHit && !patternMatch) |=> xferReq ##0 q.chan == CH_ACTIVE)
    else $error("start irq did not launch a cell");

  a_strobes_read_zero: assert property (
    (pready && paddr == CHAN_EVENT_OFS && !pwrite) |-> prdata[FORCE_BIT:ABORT_BIT] == 2'b00)
    else $error("force or abort strobe reads back set");

  a_ip_upper_zero: assert property (
    (pready && paddr == CRC_SEED_OFS && q.crcType && !pwrite) |-> prdata[31:16] == 16'h0000)
    else $error("checksum mode upper half not zero");

  a_lfsr_len_mask: assert property (
    (pready && paddr == CRC_SEED_OFS && !q.crcType && !pwrite)
      |-> (prdata & ~lenMask(q.polyLen)) == 32'h00000000)
    else $error("crc bits above length read nonzero");

  a_read_latency: assert property (
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("apb answer not one wait state");

  a_pattern_clears_on: assert property (
    (patternMatch && q.patAbortEn && q.chan != CH_IDLE && !abortHit) |=> !chanOn && !xferReq)
    else $error("pattern match left channel running");

  a_pattern_off_inert: assert property (
    (q.chan != CH_IDLE && !q.patAbortEn && !abortHit && !cellDone) |=> xferReq)
    else $error("transfer ended without cause");

  a_off_irq_ignored: assert property (
    (irqValid && !q.abortIrqEn && irqNum == q.abortIrq && q.chan != CH_IDLE && !cellDone
      && !patternMatch && !wrEn) |=> xferReq)
    else $error("disabled abort irq ended the transfer");

  a_chain_sets_on: assert property (
    (q.chan == CH_IDLE && q.chainAllow && (q.chainDir ? lowerChainDone : higherChainDone))
      |=> chanOn)
    else $error("chain completion did not enable channel");

  a_chain_blocked: assert property (
    (!q.chainAllow && !q.chanOn && !wrEn) |=> !chanOn)
    else $error("channel enabled without chaining allowed");

  a_force_launches: assert property (
    (wrEn && paddr == CHAN_EVENT_OFS && pwdata[FORCE_BIT] && q.chanOn && q.chan == CH_IDLE
      && !abortHit) |=> xferReq)
    else $error("force write did not launch a cell");

  a_abort_one_cycle: assert property (
    xferAbort |=> !xferAbort)
    else $error("abort pulse longer than one cycle");

  c_cell_done: cover property (q.chan == CH_ACTIVE ##[1:20] cellDone);
  c_suspend: cover property (q.chan == CH_SUSPEND ##[1:20] q.chan == CH_IDLE);
  c_chain_on: cover property (!chanOn && chainHit ##1 chanOn);
  c_pattern_abort: cover property (patternMatch && q.patAbortEn && q.chan != CH_IDLE);
  c_start_hit: cover property (q.chan == CH_IDLE && startHit ##1 xferReq);

endmodule : dmc_channel

// *** verilog/dmc_pkg.sv ***
// constants, register layout and state carrier for the dma channel control block
package dmc_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] CRC_CONTROL_OFS  = 8'h00;
  localparam logic [7:0] CRC_SEED_OFS     = 8'h04;
  localparam logic [7:0] CRC_TAPS_OFS     = 8'h08;
  localparam logic [7:0] CHAN_CONTROL_OFS = 8'h0c;
  localparam logic [7:0] CHAN_EVENT_OFS   = 8'h10;
  localparam logic [7:0] CHAN_STATUS_OFS  = 8'h14;
  // crc_control fields
  localparam int CRC_TYPE_BIT  = 5;
  localparam int POLY_LENGTH_MINUS_ONE_LSB      = 8;
  localparam int POLY_LENGTH_MINUS_ONE_W        = 5;
  // channel_control fields
  localparam int BUSY_BIT      = 15;
  localparam int CHAIN_DIR_BIT = 8;
  localparam int CHAN_ON_BIT   = 7;
  localparam int EVT_OFF_BIT   = 6;
  localparam int CHAIN_OK_BIT  = 5;
  localparam int REARM_BIT     = 4;
  localparam int EVT_SEEN_BIT  = 2;
  localparam int PRIO_LSB      = 0;
  // channel_event_control fields
  localparam int ABORT_IRQ_LSB = 16;
  localparam int START_IRQ_LSB = 8;
  localparam int FORCE_BIT     = 7;
  localparam int ABORT_BIT     = 6;
  localparam int PAT_EN_BIT    = 5;
  localparam int START_EN_BIT  = 4;
  localparam int ABORT_EN_BIT  = 3;
  // channel_status fields
  localparam int ABORT_FLAG_BIT = 0;
  // reset value of the irq number fields, and the checksum width
  localparam logic [7:0] IRQ_NUM_RST = 8'hff;
  localparam int IP_SUM_W = 16;

  typedef enum logic [1:0] {
    CH_IDLE    = 2'b00,
    CH_ACTIVE  = 2'b01,
    CH_SUSPEND = 2'b11
  } dmc_chan_e;

  typedef struct packed {
    logic [31:0] crcAcc;
    logic [31:0] crcTaps;
    logic        crcType;
    logic [4:0]  polyLen;
    logic        chanOn;
    logic        eventsWhileOff;
    logic        chainAllow;
    logic        chainDir;
    logic        autoRearm;
    logic        eventSeen;
    logic [1:0]  prio;
    logic [7:0]  abortIrq;
    logic [7:0]  startIrq;
    logic        patAbortEn;
    logic        startIrqEn;
    logic        abortIrqEn;
    logic        pendStart;
    dmc_chan_e   chan;
    logic        xferReq;
    logic        xferAbort;
    logic        abortFlag;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } dmc_state_s;
endpackage : dmc_pkg

// *** verification/dmc_mover_model.sv ***
// far-side data mover model: completes each requested cell after a set delay
`timescale 1ns/1ns
module dmc_mover_model (
  input  wire logic       clk,       // system clock
  input  wire logic       reset_n,   // asynchronous reset, active low
  input  wire logic       xferReq,   // cell request from the channel
  input  wire logic       xferAbort, // abort pulse from the channel
  input  wire logic [7:0] cellDelay, // cycles from request to completion, less one
  input  wire logic       lastCell,  // current cell ends the block
  output logic            cellDone,  // cell finished, one cycle
  output logic            blockDone  // block end qualifier
);
  logic [7:0] cnt;

  // held as a level on purpose: only valid alongside cellDone, so misuse shows
  assign blockDone = lastCell;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 8'h00;
      cellDone <= 1'b0;
    end else begin
      cellDone <= 1'b0;
      if (!xferReq || xferAbort || cellDone) begin
        cnt <= 8'h00;
      end else if (cnt == cellDelay) begin
        cellDone <= 1'b1;
        cnt <= 8'h00;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule : dmc_mover_model

// *** verification/dmc_channel_test.sv ***
// self-checking bench for the dma channel control and crc registers
`timescale 1ns/1ns
module dmc_channel_test import dmc_pkg::*;;
  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, pErr;
  logic [7:0]  paddr, irqNum, cellDelay;
  logic [31:0] pwdata, prdata, crcData, rdv, first;
  logic        irqValid, lastCell, cellDone, blockDone, xferReq, xferAbort;
  logic        chanOn, chanBusy, abortFlag, abortSeen;
  logic [3:0]  pul;
  logic [1:0]  chanPriority;
  int          fails, checkCount, cycles;

  dmc_channel DUT (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irqValid(irqValid), .irqNum(irqNum), .cellDone(cellDone), .blockDone(blockDone),
    .patternMatch(pul[2]), .higherChainDone(pul[0]), .lowerChainDone(pul[1]),
    .crcValid(pul[3]), .crcData(crcData), .xferReq(xferReq), .xferAbort(xferAbort),
    .chanOn(chanOn), .chanBusy(chanBusy), .chanPriority(chanPriority), .abortFlag(abortFlag)
  );
  dmc_mover_model mover (
    .clk(clk), .reset_n(reset_n), .xferReq(xferReq), .xferAbort(xferAbort),
    .cellDelay(cellDelay), .lastCell(lastCell), .cellDone(cellDone), .blockDone(blockDone)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // latched on the rising edge itself, so a one-cycle pulse is never missed
  always @(posedge xferAbort) abortSeen = 1'b1;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      $display("unexpected at %0t: run did not finish", $time);
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  // apb master: request held until pready is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    if (n != 2) chk(32'(n), 32'h2);
    rdv = prdata;
    pErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic irq(input logic [7:0] n);
    @(posedge clk);
    irqValid <= 1'b1;
    irqNum <= n;
    @(posedge clk);
    irqValid <= 1'b0;
    irqNum <= ~n;
  endtask : irq

  task automatic pulse(input int k);
    @(posedge clk);
    pul[k] <= 1'b1;
    @(posedge clk);
    pul[k] <= 1'b0;
  endtask : pulse

  task automatic feed(input logic [31:0] d);
    @(posedge clk);
    crcData <= d;
    pul[3] <= 1'b1;
    @(posedge clk);
    pul[3] <= 1'b0;
    crcData <= ~d;
  endtask : feed

  task automatic waitLow;
    int n;
    n = 0;
    while (xferReq === 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n == 100) chk(32'h1, 32'h0);
  endtask : waitLow

  // galois shift register, msb first, width p+1
  function automatic logic [31:0] lfsr(logic [31:0] c, logic [31:0] t, logic [31:0] d, int p);
    logic fb;
    for (int i = 31; i >= 0; i--) begin
      fb = c[p] ^ d[i];
      c = (c << 1) ^ (fb ? t : 32'h0);
    end
    return c & 32'((64'h1 << (p + 1)) - 64'h1);
  endfunction : lfsr

  task automatic t_crc;
    rd(CHAN_EVENT_OFS);
    chk(rdv, 32'h00ffff00);
    rd(8'h18);
    chk({31'h0, pErr}, 32'h1);
    wr(CRC_CONTROL_OFS, 32'h00001f00);
    wr(CRC_SEED_OFS, 32'ha5c3e187);
    rd(CRC_SEED_OFS);
    chk(rdv, 32'ha5c3e187);
    wr(CRC_CONTROL_OFS, 32'h00000f00);
    wr(CRC_TAPS_OFS, 32'h00001021);
    wr(CRC_SEED_OFS, 32'hffffffff);
    rd(CRC_SEED_OFS);
    chk(rdv, 32'h0000ffff);
    feed(32'h12345678);
    rd(CRC_SEED_OFS);
    chk(rdv, lfsr(32'hffffffff, 32'h1021, 32'h12345678, 15));
    wr(CRC_CONTROL_OFS, 32'h00000020);
    wr(CRC_SEED_OFS, 32'h12345678);
    rd(CRC_SEED_OFS);
    chk(rdv, 32'h0000a987);
    wr(CRC_TAPS_OFS, 32'h0);
    wr(CRC_SEED_OFS, 32'h0);
    feed(32'h8123abcd);
    rd(CRC_SEED_OFS);
    first = rdv;
    chk(rdv, 32'h0000d30e);
    chk(rdv[31:16], 32'h0);
    wr(CRC_TAPS_OFS, 32'hffffffff);
    wr(CRC_SEED_OFS, 32'h0);
    feed(32'h8123abcd);
    rd(CRC_SEED_OFS);
    chk(rdv, first);
    $display("test crc done");
  endtask : t_crc

  task automatic t_start;
    wr(CHAN_EVENT_OFS, 32'h00ff2100);
    wr(CHAN_CONTROL_OFS, 32'h80);
    irq(8'h21);
    wt(2);
    chk(xferReq, 32'h0);
    wr(CHAN_EVENT_OFS, 32'h00402110);
    irq(8'h20);
    wt(2);
    chk(xferReq, 32'h0);
    irq(8'h21);
    wt(1);
    chk({chanBusy, xferReq}, 32'h3);
    rd(CHAN_CONTROL_OFS);
    chk(rdv, 32'h8084);
    waitLow();
    wt(2);
    chk({chanOn, chanBusy}, 32'h0);
    wr(CHAN_CONTROL_OFS, 32'h90);
    irq(8'h21);
    waitLow();
    wt(2);
    chk(chanOn, 32'h1);
    cellDelay <= 8'd30;
    irq(8'h21);
    wt(1);
    wr(CHAN_CONTROL_OFS, 32'h0);
    wt(1);
    chk({chanBusy, xferReq, chanOn}, 32'h6);
    waitLow();
    wt(2);
    chk(chanBusy, 32'h0);
    $display("test start done");
  endtask : t_start

  task automatic t_abort;
    wr(CHAN_CONTROL_OFS, 32'h80);
    irq(8'h21);
    irq(8'h40);
    wt(2);
    chk(xferReq, 32'h1);
    wr(CHAN_EVENT_OFS, 32'h00402118);
    abortSeen = 1'b0;
    irq(8'h40);
    wt(2);
    chk({abortSeen, xferReq, abortFlag}, 32'h5);
    rd(CHAN_STATUS_OFS);
    chk(rdv, 32'h1);
    wr(CHAN_STATUS_OFS, 32'h1);
    wr(CHAN_CONTROL_OFS, 32'h80);
    wr(CHAN_EVENT_OFS, 32'h00402198);
    wt(1);
    chk(xferReq, 32'h1);
    rd(CHAN_EVENT_OFS);
    chk(rdv, 32'h00402118);
    abortSeen = 1'b0;
    wr(CHAN_EVENT_OFS, 32'h00402158);
    wt(2);
    chk({abortSeen, xferReq}, 32'h2);
    rd(CHAN_EVENT_OFS);
    chk(rdv, 32'h00402118);
    $display("test abort done");
  endtask : t_abort

  task automatic t_events;
    cellDelay <= 8'd6;
    wr(CHAN_CONTROL_OFS, 32'h0);
    irq(8'h21);
    wr(CHAN_CONTROL_OFS, 32'h80);
    wt(2);
    chk(xferReq, 32'h0);
    wr(CHAN_CONTROL_OFS, 32'h40);
    irq(8'h21);
    wt(2);
    chk(xferReq, 32'h0);
    rd(CHAN_CONTROL_OFS);
    chk(rdv, 32'h44);
    wr(CHAN_CONTROL_OFS, 32'hc0);
    wt(2);
    chk(xferReq, 32'h1);
    waitLow();
    lastCell <= 1'b0;
    wr(CHAN_CONTROL_OFS, 32'h80);
    irq(8'h21);
    waitLow();
    wt(2);
    chk(chanOn, 32'h1);
    lastCell <= 1'b1;
    $display("test events done");
  endtask : t_events

  task automatic t_chain;
    wr(CHAN_CONTROL_OFS, 32'h100);
    pulse(1);
    wt(1);
    chk(chanOn, 32'h0);
    wr(CHAN_CONTROL_OFS, 32'h120);
    pulse(0);
    wt(1);
    chk(chanOn, 32'h0);
    pulse(1);
    wt(1);
    chk(chanOn, 32'h1);
    wr(CHAN_CONTROL_OFS, 32'h20);
    pulse(1);
    wt(1);
    chk(chanOn, 32'h0);
    pulse(0);
    wt(1);
    chk(chanOn, 32'h1);
    $display("test chain done");
  endtask : t_chain

  task automatic t_pattern;
    cellDelay <= 8'd40;
    wr(CHAN_EVENT_OFS, 32'h00402110);
    wr(CHAN_CONTROL_OFS, 32'h90);
    irq(8'h21);
    pulse(2);
    wt(2);
    chk({chanOn, xferReq}, 32'h3);
    abortSeen = 1'b0;
    wr(CHAN_EVENT_OFS, 32'h00402130);
    pulse(2);
    wt(2);
    chk({abortSeen, chanOn, xferReq}, 32'h4);
    for (int i = 0; i < 4; i++) begin
      wr(CHAN_CONTROL_OFS, 32'(i));
      rd(CHAN_CONTROL_OFS);
      chk({chanPriority, rdv[1:0]}, 32'(i * 5));
    end
    $display("test pattern and priority done");
  endtask : t_pattern

  initial begin
    {psel, penable, pwrite, irqValid, abortSeen} = '0;
    {paddr, irqNum, pwdata, crcData, pul} = '0;
    cellDelay = 8'd6;
    lastCell = 1'b1;
    reset_n = 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_crc();
    t_start();
    t_abort();
    t_events();
    t_chain();
    t_pattern();
    tally_and_finish();
  end
endmodule : dmc_channel_test
